// *** core/ds0_mon_cfg.svh ***
// Purpose: Register indexes, field positions, reset values and frame counts.
// Assumes: Byte address is four times the register index.
// Notes:   Definitions only.
`ifndef DS0_MON_CFG_SVH
`define DS0_MON_CFG_SVH

// Register indexes; byte address = index * 4
`define IDX_TX_CTL      5'h19
`define IDX_TX_SNOOP    5'h1A
`define IDX_RX_CTL      5'h1E
`define IDX_RX_SNOOP    5'h1F

// Field positions inside the control registers
`define POS_JAPAN_CRC   7
`define POS_RX_ALIGN    6
`define POS_TX_ALIGN    5
`define SEL_MSB         4

// Writable bits and reset values
`define TX_CTL_WMASK    8'h9F
`define RX_CTL_WMASK    8'hFF
`define CTL_RESET       8'h00
`define SNOOP_RESET     8'h00

// T1 frame: one framing bit then 24 channels of 8 bits
`define FRAME_BITS      193
`define CHAN_COUNT      24
`define HALF_FRAME      9'h060

`endif

// *** core/ds0_mon_pkg.sv ***
// Purpose: Shared types of the channel monitor and store align block.
// Assumes: Constants live in ds0_mon_cfg.svh.
// Notes:   Types only.
package ds0_mon_pkg;
  typedef logic [4:0] chan_sel_t;
  typedef logic [7:0] byte_t;
  typedef logic [8:0] store_sep_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;
endpackage

// *** core/ds0_tap.sv ***
// Purpose: Picks one channel out of a serial T1 stream and holds it as a byte.
// Assumes: Line clock, data and frame sync are pins, asynchronous to clk_i.
// Notes:   Frame sync is high during the framing bit.
`timescale 1ns/1ns
`default_nettype none
`include "ds0_mon_cfg.svh"

module ds0_tap #(
  parameter int FRAME_BITS = `FRAME_BITS
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // Line pins
  input  wire logic               line_clk_i,
  input  wire logic               line_data_i,
  input  wire logic               frame_sync_i,
  // Control and result
  input  wire ds0_mon_pkg::chan_sel_t chan_sel_i,
  output var  ds0_mon_pkg::byte_t snoop_o
);
  import ds0_mon_pkg::*;

  // The position counter and channel decode only serve the one T1 frame length
  if (FRAME_BITS != `CHAN_COUNT * 8 + 1) begin : g_bad_frame
    $error("ds0_tap: FRAME_BITS must be one framing bit plus 24 channels");
  end

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic       clk_prev_reg;
  logic [7:0] pos_reg;
  logic       locked_reg;
  logic [6:0] shift_reg;

  // Second stage only feeds the edge detector and data users
  wire       line_rise = sync_reg[0] && !clk_prev_reg;
  wire       data_bit  = sync_reg[1];
  wire       fsync     = sync_reg[2];
  wire [7:0] pos_m1    = pos_reg - 8'h01;
  wire [4:0] chan_num  = 5'(pos_m1[7:3]) + 5'h01;
  wire       in_chan   = locked_reg && (pos_reg != 8'h00) && (chan_num == chan_sel_i);
  wire       cap       = line_rise && !fsync && in_chan && (pos_m1[2:0] == 3'h7);

  // Two-flop synchronisers for clock, data and frame sync
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg     <= 3'h0;
      sync_reg     <= 3'h0;
      clk_prev_reg <= 1'b0;
    end else begin
      meta_reg     <= {frame_sync_i, line_data_i, line_clk_i};
      sync_reg     <= meta_reg;
      clk_prev_reg <= sync_reg[0];
    end
  end

  // Bit position in frame; framing bit is position 0
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_reg    <= 8'h00;
      locked_reg <= 1'b0;
    end else if (line_rise) begin
      if (fsync) begin
        pos_reg    <= 8'h01;
        locked_reg <= 1'b1;
      end else if (pos_reg == 8'(FRAME_BITS - 1)) begin
        pos_reg <= 8'h00;
      end else begin
        pos_reg <= pos_reg + 8'h01;
      end
    end
  end

  // First bit shifts toward bit 7; byte posted whole so reads never mix frames
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg <= 7'h00;
      snoop_o   <= `SNOOP_RESET;
    end else begin
      if (line_rise && in_chan)
        shift_reg <= {shift_reg[5:0], data_bit};
      if (cap)
        snoop_o <= {shift_reg, data_bit};
    end
  end

  // Snoop byte moves only on a capture
  AST_SNOOP_STEADY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !cap |=> $stable(snoop_o))
    else $error("snoop byte changed without a channel capture");

  // Last line bit lands in bit 0, earlier bits above it
  AST_SNOOP_ORDER: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cap |=> (snoop_o[0] == $past(data_bit)) && (snoop_o[7:1] == $past(shift_reg)))
    else $error("snoop byte bit order wrong");

endmodule
`default_nettype wire

// *** core/ds0_monitor_and_store_align.sv ***
// Purpose: Channel monitor selects, Japanese CRC selects and store align triggers.
// Assumes: Avalon-MM slave, byte address, 32-bit data in low byte; one clock.
// Notes:   Store separations come from the elastic stores on the same clock.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ds0_mon_cfg.svh"

module ds0_monitor_and_store_align (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  // Avalon-MM slave
  input  wire logic [6:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [3:0]              avs_byteenable_i,
  input  wire logic [31:0]             avs_writedata_i,
  output var  logic [31:0]             avs_readdata_o,
  output var  logic                    avs_waitrequest_o,
  // Transmit line pins
  input  wire logic                    tx_line_clk_i,
  input  wire logic                    tx_line_data_i,
  input  wire logic                    tx_frame_sync_i,
  // Receive line pins
  input  wire logic                    rx_line_clk_i,
  input  wire logic                    rx_line_data_i,
  input  wire logic                    rx_frame_sync_i,
  // Elastic store separations, in bits
  input  wire ds0_mon_pkg::store_sep_t tx_store_sep_i,
  input  wire ds0_mon_pkg::store_sep_t rx_store_sep_i,
  // Controls to the framer
  output var  logic                    tx_japan_crc_enable_o,
  output var  logic                    rx_japan_crc_enable_o,
  output var  logic                    tx_store_align_o,
  output var  logic                    rx_store_align_o
);
  import ds0_mon_pkg::*;

  bus_state_t state_reg;
  bus_state_t state_next;
  byte_t      tx_ctl_reg;
  byte_t      rx_ctl_reg;
  byte_t      tx_snoop;
  byte_t      rx_snoop;
  byte_t      rd_byte;

  // Address decode and write strobes
  wire [4:0] reg_idx   = avs_address_i[6:2];
  wire       req       = avs_read_i || avs_write_i;
  wire       wr_fire   = (state_reg == BUS_DONE) && avs_write_i && avs_byteenable_i[0];
  wire       wr_tx_ctl = wr_fire && (reg_idx == `IDX_TX_CTL);
  wire       wr_rx_ctl = wr_fire && (reg_idx == `IDX_RX_CTL);
  wire [7:0] wbyte     = avs_writedata_i[7:0];

  // Unassigned bits are dropped so they always read back zero
  wire [7:0] tx_ctl_next = wr_tx_ctl ? (wbyte & `TX_CTL_WMASK) : tx_ctl_reg;
  wire [7:0] rx_ctl_next = wr_rx_ctl ? (wbyte & `RX_CTL_WMASK) : rx_ctl_reg;

  // Align requests are edge-triggered on the stored bit, not on the level
  wire rx_align_rise = wr_rx_ctl && wbyte[`POS_RX_ALIGN] && !rx_ctl_reg[`POS_RX_ALIGN];
  wire tx_align_rise = wr_rx_ctl && wbyte[`POS_TX_ALIGN] && !rx_ctl_reg[`POS_TX_ALIGN];
  wire rx_align_next = rx_align_rise && (rx_store_sep_i <= `HALF_FRAME);
  wire tx_align_next = tx_align_rise && (tx_store_sep_i <= `HALF_FRAME);

  // Read mux; unmapped offsets read zero
  assign rd_byte = (reg_idx == `IDX_TX_CTL)   ? tx_ctl_reg :
                   (reg_idx == `IDX_TX_SNOOP) ? tx_snoop   :
                   (reg_idx == `IDX_RX_CTL)   ? rx_ctl_reg :
                   (reg_idx == `IDX_RX_SNOOP) ? rx_snoop   : 8'h00;

  // One wait cycle per access; the DONE cycle drops waitrequest
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BUS_IDLE: begin
        if (req)
          state_next = BUS_DONE;
      end
      BUS_DONE: begin
        state_next = BUS_IDLE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  // Bus handshake and read data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg         <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      state_reg         <= state_next;
      avs_waitrequest_o <= (state_next != BUS_DONE);
      if (state_reg == BUS_IDLE && req)
        avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // Control registers and their outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_ctl_reg            <= `CTL_RESET;
      rx_ctl_reg            <= `CTL_RESET;
      tx_japan_crc_enable_o <= 1'b0;
      rx_japan_crc_enable_o <= 1'b0;
      tx_store_align_o      <= 1'b0;
      rx_store_align_o      <= 1'b0;
    end else begin
      tx_ctl_reg            <= tx_ctl_next;
      rx_ctl_reg            <= rx_ctl_next;
      tx_japan_crc_enable_o <= tx_ctl_next[`POS_JAPAN_CRC];
      rx_japan_crc_enable_o <= rx_ctl_next[`POS_JAPAN_CRC];
      tx_store_align_o      <= tx_align_next;
      rx_store_align_o      <= rx_align_next;
    end
  end

  // One tap per direction; a select of 0 or above 24 freezes the byte
  ds0_tap u_tx_tap (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .line_clk_i   (tx_line_clk_i),
    .line_data_i  (tx_line_data_i),
    .frame_sync_i (tx_frame_sync_i),
    .chan_sel_i   (tx_ctl_reg[`SEL_MSB:0]),
    .snoop_o      (tx_snoop)
  );

  ds0_tap u_rx_tap (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .line_clk_i   (rx_line_clk_i),
    .line_data_i  (rx_line_data_i),
    .frame_sync_i (rx_frame_sync_i),
    .chan_sel_i   (rx_ctl_reg[`SEL_MSB:0]),
    .snoop_o      (rx_snoop)
  );

  // Named steps of a register write
  sequence s_wr_tx_ctl;
    wr_tx_ctl;
  endsequence

  sequence s_wr_rx_ctl;
    wr_rx_ctl;
  endsequence

  // Request with waitrequest high is answered on the next edge
  AST_WAIT_ONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest did not drop for exactly one cycle");

  AST_TX_JCRC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_wr_tx_ctl |=> (tx_japan_crc_enable_o == $past(wbyte[7])))
    else $error("transmit Japanese CRC enable does not follow write");

  AST_RX_JCRC: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_wr_rx_ctl |=> (rx_japan_crc_enable_o == $past(wbyte[7])))
    else $error("receive Japanese CRC select does not follow write");

  AST_TX_RESERVED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == BUS_IDLE && avs_read_i && reg_idx == `IDX_TX_CTL)
      |=> (avs_readdata_o[6:5] == 2'b00))
    else $error("unassigned transmit control bits read nonzero");

  AST_RX_ALIGN_RISE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s_wr_rx_ctl ##0 (wbyte[6] && !rx_ctl_reg[6] && rx_store_sep_i <= `HALF_FRAME))
      |=> rx_store_align_o)
    else $error("receive align rise did not recenter");

  AST_TX_ALIGN_RISE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s_wr_rx_ctl ##0 (wbyte[5] && !rx_ctl_reg[5] && tx_store_sep_i <= `HALF_FRAME))
      |=> tx_store_align_o)
    else $error("transmit align rise did not recenter");

  AST_ALIGN_FAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rx_store_sep_i > `HALF_FRAME) |=> !rx_store_align_o)
    else $error("receive store realigned although already apart");

  AST_ALIGN_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rx_ctl_reg[6] && !wr_rx_ctl) |=> !rx_store_align_o [*2])
    else $error("receive align fired on a held level");

  // Transmit store already far apart: a rising align bit stays quiet
  AST_TX_ALIGN_FAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_store_sep_i > `HALF_FRAME) |=> !tx_store_align_o)
    else $error("transmit store realigned although already apart");

  // A held transmit align bit must not pulse again
  AST_TX_ALIGN_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rx_ctl_reg[5] && !wr_rx_ctl) |=> !tx_store_align_o [*2])
    else $error("transmit align fired on a held level");

  // Align requests are single-cycle pulses; accesses are two cycles apart at best
  AST_ALIGN_PULSE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rx_store_align_o || tx_store_align_o) |=> !(rx_store_align_o || tx_store_align_o))
    else $error("align request lasted more than one cycle");

  // A write without byte lane 0 is answered but leaves both control bytes alone
  AST_LANE_GATED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == BUS_DONE && avs_write_i && !avs_byteenable_i[0])
      |=> ($stable(tx_ctl_reg) && $stable(rx_ctl_reg)))
    else $error("write without byte lane 0 changed a control byte");

  // Only the low lane carries register data
  AST_READ_UPPER: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !avs_waitrequest_o |-> (avs_readdata_o[31:8] == 24'h00_0000))
    else $error("read data upper lanes nonzero");

endmodule
`default_nettype wire

// *** test/ds0_monitor_and_store_align_tb.sv ***
// Purpose: Self-checking bench for the channel monitor and store align block.
// Assumes: Avalon-MM slave with one wait cycle; line pins driven from clk_i edges.
// Notes:   Line clocks stand still between frames; each bit lasts 6 clk_i cycles.
`timescale 1ns/1ns
`default_nettype none
`include "ds0_mon_cfg.svh"

module ds0_monitor_and_store_align_tb;
  import ds0_mon_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [6:0]  avs_address_i = 7'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        tx_clk = 1'b0, tx_dat = 1'b0, tx_fs = 1'b0;
  logic        rx_clk = 1'b0, rx_dat = 1'b0, rx_fs = 1'b0;
  store_sep_t  tx_sep = 9'h000, rx_sep = 9'h000;
  logic        tx_jc, rx_jc, tx_al, rx_al;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycles = 0;
  localparam logic [6:0] A_TXC = {`IDX_TX_CTL, 2'b00};
  localparam logic [6:0] A_TXS = {`IDX_TX_SNOOP, 2'b00};
  localparam logic [6:0] A_RXC = {`IDX_RX_CTL, 2'b00};
  localparam logic [6:0] A_RXS = {`IDX_RX_SNOOP, 2'b00};

  ds0_monitor_and_store_align ds0_monitor_and_store_align_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .tx_line_clk_i(tx_clk), .tx_line_data_i(tx_dat),
    .tx_frame_sync_i(tx_fs), .rx_line_clk_i(rx_clk), .rx_line_data_i(rx_dat),
    .rx_frame_sync_i(rx_fs), .tx_store_sep_i(tx_sep), .rx_store_sep_i(rx_sep),
    .tx_japan_crc_enable_o(tx_jc), .rx_japan_crc_enable_o(rx_jc),
    .tx_store_align_o(tx_al), .rx_store_align_o(rx_al));

  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 2500 cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_check(input logic [6:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, e});
  endtask

  task automatic test_reset();
    rd_check(A_TXC, `CTL_RESET);
    rd_check(A_RXC, `CTL_RESET);
    rd_check(A_TXS, `SNOOP_RESET);
    rd_check(A_RXS, `SNOOP_RESET);
    rd_check(7'h00, 8'h00);
    check({tx_jc, rx_jc, tx_al, rx_al}, 4'h0);
  endtask

  // Japanese CRC selects, byte lane 0 gating and an unmapped offset
  task automatic test_crc();
    wr(A_TXC, 8'h9F);
    @(posedge clk_i);
    check({tx_jc, rx_jc}, 2'b10);
    rd_check(A_TXC, 8'h9F);
    avs_byteenable_i <= 4'hE;
    wr(A_TXC, 8'h00);
    avs_byteenable_i <= 4'hF;
    rd_check(A_TXC, 8'h9F);
    check({tx_jc, rx_jc}, 2'b10);
    wr(A_RXC, 8'h80);
    @(posedge clk_i);
    check({tx_jc, rx_jc}, 2'b11);
    wr(A_TXC, 8'h00);
    wr(A_RXC, 8'h00);
    @(posedge clk_i);
    check({tx_jc, rx_jc}, 2'b00);
    wr(7'h00, 8'hFF);
    rd_check(7'h00, 8'h00);
  endtask

  // Write the receive control byte and watch both align pulses for two cycles
  task automatic align_step(input logic [7:0] d, input logic [1:0] e);
    wr(A_RXC, d);
    @(posedge clk_i);
    check({rx_al, tx_al}, e);
    @(posedge clk_i);
    check({rx_al, tx_al}, 2'b00);
  endtask

  task automatic test_align();
    logic [7:0] b;
    // Backplane clocks count as running from reset, so aligns may be toggled at once
    for (int s = 0; s < 2; s++) begin
      b = s ? 8'h40 : 8'h20;
      tx_sep <= `HALF_FRAME;
      rx_sep <= `HALF_FRAME;
      align_step(b, s ? 2'b10 : 2'b01);
      align_step(b, 2'b00);
      align_step(8'h00, 2'b00);
      tx_sep <= `HALF_FRAME + 9'h001;
      rx_sep <= `HALF_FRAME + 9'h001;
      align_step(b, 2'b00);
      align_step(8'h00, 2'b00);
      tx_sep <= 9'h000;
      rx_sep <= 9'h000;
      align_step(b, s ? 2'b10 : 2'b01);
      align_step(8'h00, 2'b00);
    end
  endtask

  // Bit at frame position p: channel bits first-sent at bit 7, else a toggle pattern
  function automatic logic pick(input int p, input int ch, input byte_t v);
    if (p > 8 * (ch - 1) && p <= 8 * ch) return v[8 * ch - p];
    return p[0];
  endfunction

  task automatic frame(input byte_t tv, input byte_t rv);
    for (int p = 0; p < `FRAME_BITS; p++) begin
      @(posedge clk_i);
      {tx_clk, rx_clk} <= 2'b00;
      {tx_fs, rx_fs} <= {2{p == 0}};
      tx_dat <= pick(p, 6, tv);
      rx_dat <= pick(p, 15, rv);
      repeat (3) @(posedge clk_i);
      {tx_clk, rx_clk} <= 2'b11;
      repeat (2) @(posedge clk_i);
    end
    @(posedge clk_i);
    {tx_clk, rx_clk} <= 2'b00;
    repeat (8) @(posedge clk_i);
  endtask

  // Transmit channel 6 and receive channel 15, two frames in a row
  task automatic test_line();
    wr(A_TXC, 8'h06);
    wr(A_RXC, 8'h0F);
    frame(8'h5A, 8'hC3);
    rd_check(A_TXS, 8'h5A);
    rd_check(A_RXS, 8'hC3);
    wr(A_TXS, 8'hFF);
    rd_check(A_TXS, 8'h5A);
    frame(8'hA5, 8'h3C);
    rd_check(A_TXS, 8'hA5);
    rd_check(A_RXS, 8'h3C);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    test_reset();
    test_crc();
    test_align();
    test_line();
    finish_test();
  end
endmodule
`default_nettype wire
